/* src/fprmd_top.v */
/*
 * fan pwm ramp limiter for outputs two and three and floor duty registers for all three outputs, with an
 * apb slave. assumes the control loop supplies raw targets over registers
 * and that pwm outputs feed fan drivers directly.
 */
// The implementer's own choice: register access over APB.
`timescale 1ns/10ps
`include "fprmd_regs.vh"
module fprmd_top (
  input  wire        CLOCK,
  input  wire        NRST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [9:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  output reg  [2:0]  PWM_OUT
);
  reg  [7:0]  floor1_reg;
  reg  [7:0]  floor2_reg;
  reg  [7:0]  floor3_reg;
  reg  [7:0]  slew_reg;
  reg  [4:0]  mode_reg;
  reg  [7:0]  tgt1_reg;
  reg  [7:0]  tgt2_reg;
  reg  [7:0]  tgt3_reg;
  reg  [7:0]  pcnt_reg;
  reg  [31:0] slot_reg;
  reg         slot_tick_reg;
  reg  [31:0] rdata_next;
  reg         err_next;
  wire        period_tick;
  wire        acc;
  wire        wr;
  wire [3:0]  sel_code;
  wire        wr_floor1;
  wire        wr_floor2;
  wire        wr_floor3;
  wire        wr_slew;
  wire        wr_mode;
  wire        wr_tgt1;
  wire        wr_tgt2;
  wire        wr_tgt3;
  wire        auto_mode;
  wire [7:0]  eff1;
  wire [7:0]  eff2;
  wire [7:0]  eff3;
  wire [7:0]  duty1;
  wire [7:0]  duty2;
  wire [7:0]  duty3;

  // select codes from the address decoder, one per register
  localparam [3:0] code_none   = 4'h0;
  localparam [3:0] code_floor1 = 4'h1;
  localparam [3:0] code_floor2 = 4'h2;
  localparam [3:0] code_floor3 = 4'h3;
  localparam [3:0] code_slew   = 4'h4;
  localparam [3:0] code_mode   = 4'h5;
  localparam [3:0] code_tgt1   = 4'h6;
  localparam [3:0] code_tgt2   = 4'h7;
  localparam [3:0] code_tgt3   = 4'h8;
  localparam [3:0] code_duty1  = 4'h9;
  localparam [3:0] code_duty2  = 4'hA;
  localparam [3:0] code_duty3  = 4'hB;

  // byte address to select code; unaligned or unmapped gives code_none
  function [3:0] decode_addr;
    input [9:0] addr;
    begin
      if (addr == `FPRMD_OFF_FLOOR1)
        decode_addr = code_floor1;
      else if (addr == `FPRMD_OFF_FLOOR2)
        decode_addr = code_floor2;
      else if (addr == `FPRMD_OFF_FLOOR3)
        decode_addr = code_floor3;
      else if (addr == `FPRMD_OFF_SLEW)
        decode_addr = code_slew;
      else if (addr == `FPRMD_OFF_MODE)
        decode_addr = code_mode;
      else if (addr == `FPRMD_OFF_TARGET1)
        decode_addr = code_tgt1;
      else if (addr == `FPRMD_OFF_TARGET2)
        decode_addr = code_tgt2;
      else if (addr == `FPRMD_OFF_TARGET3)
        decode_addr = code_tgt3;
      else if (addr == `FPRMD_OFF_DUTY1)
        decode_addr = code_duty1;
      else if (addr == `FPRMD_OFF_DUTY2)
        decode_addr = code_duty2;
      else if (addr == `FPRMD_OFF_DUTY3)
        decode_addr = code_duty3;
      else
        decode_addr = code_none;
    end
  endfunction

  // target seen by pwm: in auto below threshold, select 0% or floor
  function [7:0] eff_target;
    input       auto_on;
    input       below;
    input       sel;
    input [7:0] floor;
    input [7:0] tgt;
    begin
      if (auto_on && below)
        eff_target = sel ? floor : `FPRMD_ZERO8;
      else
        eff_target = tgt;
    end
  endfunction

  // linear compare: 0x00 never high, 0xFF always high
  function pwm_level;
    input [7:0] duty;
    input [7:0] cnt;
    begin
      if (duty == 8'hFF)
        pwm_level = 1'b1;
      else
        pwm_level = (cnt < duty);
    end
  endfunction

  assign acc       = PSEL && PENABLE;
  // a write lands at the edge that samples the answer, never earlier
  assign wr        = acc && PWRITE && PREADY;
  assign sel_code  = decode_addr(PADDR);
  assign auto_mode = mode_reg[`FPRMD_MODE_AUTO_BIT];
  assign period_tick = (pcnt_reg == 8'hFF);

  assign eff1 = eff_target(auto_mode, mode_reg[`FPRMD_MODE_BELOW_BIT],
                           mode_reg[`FPRMD_MODE_SEL1_BIT], floor1_reg,
                           tgt1_reg);
  assign eff2 = eff_target(auto_mode, mode_reg[`FPRMD_MODE_BELOW_BIT],
                           mode_reg[`FPRMD_MODE_SEL2_BIT], floor2_reg,
                           tgt2_reg);
  assign eff3 = eff_target(auto_mode, mode_reg[`FPRMD_MODE_BELOW_BIT],
                           mode_reg[`FPRMD_MODE_SEL3_BIT], floor3_reg,
                           tgt3_reg);

  // write strobes; floors refuse writes while automatic control owns them
  assign wr_floor1 = wr && (sel_code == code_floor1) && !auto_mode;
  assign wr_floor2 = wr && (sel_code == code_floor2) && !auto_mode;
  assign wr_floor3 = wr && (sel_code == code_floor3) && !auto_mode;
  assign wr_slew   = wr && (sel_code == code_slew);
  assign wr_mode   = wr && (sel_code == code_mode);
  assign wr_tgt1   = wr && (sel_code == code_tgt1);
  assign wr_tgt2   = wr && (sel_code == code_tgt2);
  assign wr_tgt3   = wr && (sel_code == code_tgt3);

  // floor duty of output one
  always @(posedge CLOCK) begin
    if (!NRST)
      floor1_reg <= `FPRMD_FLOOR_RST;
    else if (wr_floor1)
      floor1_reg <= PWDATA[7:0];
  end

  // floor duty of output two
  always @(posedge CLOCK) begin
    if (!NRST)
      floor2_reg <= `FPRMD_FLOOR_RST;
    else if (wr_floor2)
      floor2_reg <= PWDATA[7:0];
  end

  // floor duty of output three
  always @(posedge CLOCK) begin
    if (!NRST)
      floor3_reg <= `FPRMD_FLOOR_RST;
    else if (wr_floor3)
      floor3_reg <= PWDATA[7:0];
  end

  // ramp enables and rate codes of outputs two and three
  always @(posedge CLOCK) begin
    if (!NRST)
      slew_reg <= `FPRMD_ZERO8;
    else if (wr_slew)
      slew_reg <= PWDATA[7:0];
  end

  // auto bit, floor selects and below-threshold flag
  always @(posedge CLOCK) begin
    if (!NRST)
      mode_reg <= 5'h00;
    else if (wr_mode)
      mode_reg <= PWDATA[4:0];
  end

  // raw target of output one from the control loop
  always @(posedge CLOCK) begin
    if (!NRST)
      tgt1_reg <= `FPRMD_ZERO8;
    else if (wr_tgt1)
      tgt1_reg <= PWDATA[7:0];
  end

  // raw target of output two
  always @(posedge CLOCK) begin
    if (!NRST)
      tgt2_reg <= `FPRMD_ZERO8;
    else if (wr_tgt2)
      tgt2_reg <= PWDATA[7:0];
  end

  // raw target of output three
  always @(posedge CLOCK) begin
    if (!NRST)
      tgt3_reg <= `FPRMD_ZERO8;
    else if (wr_tgt3)
      tgt3_reg <= PWDATA[7:0];
  end

  // read mux and error answer for unmapped or unaligned addresses
  always @* begin
    rdata_next = 32'h00000000;
    err_next   = 1'b0;
    case (sel_code)
      code_floor1: rdata_next = {24'h000000, floor1_reg};
      code_floor2: rdata_next = {24'h000000, floor2_reg};
      code_floor3: rdata_next = {24'h000000, floor3_reg};
      code_slew:   rdata_next = {24'h000000, slew_reg};
      code_mode:   rdata_next = {27'h0000000, mode_reg};
      code_tgt1:   rdata_next = {24'h000000, tgt1_reg};
      code_tgt2:   rdata_next = {24'h000000, tgt2_reg};
      code_tgt3:   rdata_next = {24'h000000, tgt3_reg};
      code_duty1:  rdata_next = {24'h000000, duty1};
      code_duty2:  rdata_next = {24'h000000, duty2};
      code_duty3:  rdata_next = {24'h000000, duty3};
      default:     err_next = 1'b1;
    endcase
  end

  // registered answer: pready rises one cycle into the access phase,
  // which costs a wait state but keeps every bus output on a flop
  always @(posedge CLOCK) begin
    if (!NRST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h00000000;
    end else begin
      PREADY  <= acc && !PREADY;
      PSLVERR <= acc && !PREADY && err_next;
      PRDATA  <= (acc && !PREADY && !PWRITE) ? rdata_next : 32'h00000000;
    end
  end

  // pwm period counter and ramp slot timer
  always @(posedge CLOCK) begin
    if (!NRST) begin
      pcnt_reg      <= `FPRMD_ZERO8;
      slot_reg      <= 32'h00000000;
      slot_tick_reg <= 1'b0;
    end else begin
      pcnt_reg <= pcnt_reg + 8'h01;
      if (slot_reg == `FPRMD_SLOT_CYCLES - 1) begin
        slot_reg      <= 32'h00000000;
        slot_tick_reg <= 1'b1;
      end else begin
        slot_reg      <= slot_reg + 32'h00000001;
        slot_tick_reg <= 1'b0;
      end
    end
  end

  // output one has no slew control here, it follows target per period
  fprmd_slew u_ch1 (
    .clk         (CLOCK),
    .nrst        (NRST),
    .enable      (1'b0),
    .rate        (3'h0),
    .slot_tick   (slot_tick_reg),
    .period_tick (period_tick),
    .target      (eff1),
    .duty_reg    (duty1)
  );

  fprmd_slew u_ch2 (
    .clk         (CLOCK),
    .nrst        (NRST),
    .enable      (slew_reg[`FPRMD_SLEW_EN2_BIT]),
    .rate        (slew_reg[`FPRMD_RATE2_HI:`FPRMD_RATE2_LO]),
    .slot_tick   (slot_tick_reg),
    .period_tick (period_tick),
    .target      (eff2),
    .duty_reg    (duty2)
  );

  fprmd_slew u_ch3 (
    .clk         (CLOCK),
    .nrst        (NRST),
    .enable      (slew_reg[`FPRMD_SLEW_EN3_BIT]),
    .rate        (slew_reg[`FPRMD_RATE3_HI:`FPRMD_RATE3_LO]),
    .slot_tick   (slot_tick_reg),
    .period_tick (period_tick),
    .target      (eff3),
    .duty_reg    (duty3)
  );

  // pwm outputs registered
  always @(posedge CLOCK) begin
    if (!NRST)
      PWM_OUT <= 3'h0;
    else
      PWM_OUT <= {pwm_level(duty3, pcnt_reg), pwm_level(duty2, pcnt_reg),
                  pwm_level(duty1, pcnt_reg)};
  end
endmodule // fprmd_top

/* src/fprmd_regs.vh */
/*
 * constants for the fan ramp limiter and floor duty block: register offsets,
 * field positions, reset values and ramp timing counts.
 * assumes a 10 MHz clock and an apb slave with 32-bit aligned words.
 */
// Overview of operation
// - with slew enabled, output two ramps toward each new target at chosen rate.
// - output two rate field bits 6:4, codes give steps 1,2,3,5,8,12,24,48.
// - full 33% to 100% ramp takes 35 s slowest down to 0.8 s fastest.
// - bit 3 enables ramping on output three; clear means a jump to target at the next period end.
// - bit 7 enables ramping on output two; clear disables its ramping.
// - each output has 8-bit floor duty, linear, 0x40 is 25%, 0x80 is 50%.
// - floor duty 0x00 means fan off, 0xFF means full speed.
// - floor duty registers ignore writes while automatic mode is active.
// - floor duty registers reset to 0x80.
// - output three rate field bits 2:0, same encoding as output two.
// - in auto mode below threshold, select bit picks 0% or floor duty.
`ifndef FPRMD_REGS_VH
`define FPRMD_REGS_VH

// register indices; every register owns one aligned 32-bit word, so the
// byte address on the bus is four times its index
`define FPRMD_IDX_FLOOR1    8'h64
`define FPRMD_IDX_FLOOR2    8'h65
`define FPRMD_IDX_FLOOR3    8'h66
`define FPRMD_IDX_SLEW      8'h63
`define FPRMD_IDX_MODE      8'h68
`define FPRMD_IDX_TARGET1   8'h70
`define FPRMD_IDX_TARGET2   8'h74
`define FPRMD_IDX_TARGET3   8'h78
`define FPRMD_IDX_DUTY1     8'h7C
`define FPRMD_IDX_DUTY2     8'h80
`define FPRMD_IDX_DUTY3     8'h84

// 10-bit byte addresses built from the indices
`define FPRMD_OFF_FLOOR1    {`FPRMD_IDX_FLOOR1, 2'b00}
`define FPRMD_OFF_FLOOR2    {`FPRMD_IDX_FLOOR2, 2'b00}
`define FPRMD_OFF_FLOOR3    {`FPRMD_IDX_FLOOR3, 2'b00}
`define FPRMD_OFF_SLEW      {`FPRMD_IDX_SLEW, 2'b00}
`define FPRMD_OFF_MODE      {`FPRMD_IDX_MODE, 2'b00}
`define FPRMD_OFF_TARGET1   {`FPRMD_IDX_TARGET1, 2'b00}
`define FPRMD_OFF_TARGET2   {`FPRMD_IDX_TARGET2, 2'b00}
`define FPRMD_OFF_TARGET3   {`FPRMD_IDX_TARGET3, 2'b00}
`define FPRMD_OFF_DUTY1     {`FPRMD_IDX_DUTY1, 2'b00}
`define FPRMD_OFF_DUTY2     {`FPRMD_IDX_DUTY2, 2'b00}
`define FPRMD_OFF_DUTY3     {`FPRMD_IDX_DUTY3, 2'b00}

`define FPRMD_FLOOR_RST     8'h80
`define FPRMD_ZERO8         8'h00
`define FPRMD_SLEW_EN2_BIT  7
`define FPRMD_SLEW_EN3_BIT  3
`define FPRMD_RATE2_HI      6
`define FPRMD_RATE2_LO      4
`define FPRMD_RATE3_HI      2
`define FPRMD_RATE3_LO      0
`define FPRMD_MODE_AUTO_BIT 0
`define FPRMD_MODE_SEL1_BIT 1
`define FPRMD_MODE_SEL2_BIT 2
`define FPRMD_MODE_SEL3_BIT 3
`define FPRMD_MODE_BELOW_BIT 4

// pwm period of 256 clocks; slowest ramp of 171 counts over 35 s
`define FPRMD_PWM_LEN       256
`define FPRMD_CLK_HZ        10000000
`define FPRMD_SLOW_RAMP_MS  35000
`define FPRMD_SLOW_STEPS    171
`define FPRMD_SLOT_CYCLES   ((`FPRMD_CLK_HZ / 1000) * `FPRMD_SLOW_RAMP_MS / `FPRMD_SLOW_STEPS)

`endif

/* src/fprmd_slew.v */
/*
 * one channel of duty slew: steps applied duty toward target once per slot.
 * assumes slot_tick and period_tick are one-cycle pulses on the same clock.
 */
`timescale 1ns/10ps
`include "fprmd_regs.vh"
module fprmd_slew (
  input  wire       clk,
  input  wire       nrst,
  input  wire       enable,
  input  wire [2:0] rate,
  input  wire       slot_tick,
  input  wire       period_tick,
  input  wire [7:0] target,
  output reg  [7:0] duty_reg
);
  reg  [7:0] duty_next;
  wire [7:0] step;
  wire [8:0] up_sum;
  wire [8:0] down_diff;

  // code to increment per slot
  function [7:0] rate_step;
    input [2:0] code;
    begin
      case (code)
        3'h0: rate_step = 8'h01;
        3'h1: rate_step = 8'h02;
        3'h2: rate_step = 8'h03;
        3'h3: rate_step = 8'h05;
        3'h4: rate_step = 8'h08;
        3'h5: rate_step = 8'h0C;
        3'h6: rate_step = 8'h18;
        default: rate_step = 8'h30;
      endcase
    end
  endfunction

  assign step      = rate_step(rate);
  assign up_sum    = {1'b0, duty_reg} + {1'b0, step};
  assign down_diff = {1'b0, duty_reg} - {1'b0, step};

  // next duty: ramp or jump, never past the target
  always @* begin
    duty_next = duty_reg;
    if (!enable) begin
      if (period_tick)
        duty_next = target;
    end else if (slot_tick) begin
      if (duty_reg < target) begin
        if (up_sum >= {1'b0, target})
          duty_next = target;
        else
          duty_next = up_sum[7:0];
      end else if (duty_reg > target) begin
        // borrow in bit 8 also means we would cross below the target
        if (down_diff[8] || down_diff[7:0] <= target)
          duty_next = target;
        else
          duty_next = down_diff[7:0];
      end
    end
  end

  always @(posedge clk) begin
    if (!nrst)
      duty_reg <= `FPRMD_ZERO8;
    else
      duty_reg <= duty_next;
  end
endmodule // fprmd_slew

/* dv/fprmd_checker.sv */
/* port checker for fprmd_top: apb timing, map errors, reset levels.
   assumes the slave answers one wait state after the access phase. */
`timescale 1ns/10ps
`include "fprmd_regs.vh"
module fprmd_checker (
  input wire        CLOCK,
  input wire        NRST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [9:0]  PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  input wire        PSLVERR,
  input wire [2:0]  PWM_OUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // an access phase still waiting for its answer
  wire take = PSEL && PENABLE && !PREADY;
  // must mirror the slave's decode; a gap here shows up as a false error
  wire mapped = PADDR inside {`FPRMD_OFF_SLEW, `FPRMD_OFF_FLOOR1,
    `FPRMD_OFF_FLOOR2, `FPRMD_OFF_FLOOR3, `FPRMD_OFF_MODE,
    `FPRMD_OFF_TARGET1, `FPRMD_OFF_TARGET2, `FPRMD_OFF_TARGET3,
    `FPRMD_OFF_DUTY1, `FPRMD_OFF_DUTY2, `FPRMD_OFF_DUTY3};
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_ready_wait: assert property (take |=> PREADY)
    else $error("ready late");
  a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
    else $error("ready without access");
  a_err_pair: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_rdata_idle: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  a_rdata_byte: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("read data above byte");
  a_map_error: assert property (take && !mapped |=> PSLVERR)
    else $error("unmapped access not refused");
  a_map_ok: assert property (take && mapped |=> !PSLVERR)
    else $error("mapped access refused");
  a_reset_quiet: assert property ($rose(NRST) |-> PWM_OUT == 3'h0 && !PREADY)
    else $error("outputs active after reset");
endmodule // fprmd_checker

bind fprmd_top fprmd_checker u_chk (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT));

/* dv/fprmd_fan_model.sv */
/* fan model: sums high clocks of each pwm output over 256 clocks.
   assumes pwm is a registered level on clk; start is a one-cycle pulse. */
`timescale 1ns/10ps
module fprmd_fan_model (
  input  wire       clk,
  input  wire [2:0] pwm,
  input  wire       start,
  output reg  [8:0] hi1,
  output reg  [8:0] hi2,
  output reg  [8:0] hi3,
  output reg        done
);
  reg [8:0] left = 9'h000;
  initial {hi1, hi2, hi3, done} = 28'h0;
  // a fan only feels average drive, so one full window is summed
  always @(posedge clk) begin
    if (start) begin
      {hi1, hi2, hi3, done} <= 28'h0;
      left <= 9'h100;
    end else if (left != 9'h000) begin
      hi1 <= hi1 + pwm[0];
      hi2 <= hi2 + pwm[1];
      hi3 <= hi3 + pwm[2];
      left <= left - 9'h001;
      done <= (left == 9'h001);
    end
  end
endmodule // fprmd_fan_model

/* dv/testbench.sv */
/* self-checking bench for fprmd_top with a fan model on the pwm outputs.
   assumes the one wait state apb slave and 256-clock pwm period. */
`timescale 1ns/10ps
`include "fprmd_regs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  reg         CLOCK = 1'b0;
  reg         NRST = 1'b0;
  reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0, start = 1'b0;
  reg  [9:0]  paddr = 10'h000;
  reg  [31:0] pwdata = 32'h0, rd;
  reg         err;
  wire [31:0] prdata;
  wire        pready, pslverr, done;
  wire [2:0]  pwm;
  wire [8:0]  hi1, hi2, hi3;
  reg  [7:0]  fl[3], tg[3];
  reg  [2:0]  r2, r3;
  int         n_mismatch = 0, comparisons = 0, i;
  always #50 CLOCK = ~CLOCK;
  fprmd_top dut (.CLOCK(CLOCK), .NRST(NRST), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PWM_OUT(pwm));
  fprmd_fan_model fan (.clk(CLOCK), .pwm(pwm), .start(start), .hi1(hi1),
    .hi2(hi2), .hi3(hi3), .done(done));
  task end_sim;
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one transfer; request held until pready is sampled high
  task apb(input bit w, input [9:0] a, input [31:0] d);
    int k;
    @(posedge CLOCK) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge CLOCK) penable <= 1'b1;
    for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge CLOCK);
    {rd, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
    if (k == 20) begin n_mismatch++; end_sim; end
  endtask
  task rdchk(input [9:0] a, input [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, {24'h0, e})
    `CHK(err, 1'b0)
  endtask
  // one fan window; it also lets at least one pwm period end
  task measure;
    int k;
    @(posedge CLOCK) start <= 1'b1;
    @(posedge CLOCK) start <= 1'b0;
    // done of the last window clears only at this edge; poll after it
    @(posedge CLOCK);
    for (k = 0; k < 400 && done !== 1'b1; k++) @(posedge CLOCK);
    if (k == 400) begin n_mismatch++; end_sim; end
  endtask
  function [8:0] hi_exp(input [7:0] d);
    hi_exp = (d == 8'hFF) ? 9'h100 : {1'b0, d};
  endfunction
  initial begin
    void'($urandom(32'h8420A8CE));
    repeat (8) @(posedge CLOCK);
    NRST <= 1'b1;
    for (i = 0; i < 3; i++)
      rdchk(10'(`FPRMD_OFF_FLOOR1 + 4 * i), 8'h80);
    rdchk(`FPRMD_OFF_SLEW, 8'h00);
    // floor corners plus one random value
    fl[0] = 8'hFF; fl[1] = 8'($urandom) | 8'h01; fl[2] = 8'h00;
    for (i = 0; i < 3; i++)
      apb(1'b1, 10'(`FPRMD_OFF_FLOOR1 + 4 * i), fl[i]);
    for (i = 0; i < 3; i++)
      rdchk(10'(`FPRMD_OFF_FLOOR1 + 4 * i), fl[i]);
    apb(1'b0, 10'h19C, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    // an unaligned address inside a mapped word is refused as well
    apb(1'b0, 10'h191, 32'h0);
    `CHK(err, 1'b1)
    // slew off: targets apply within one period, duty is linear
    tg[0] = 8'h40; tg[1] = 8'hFF; tg[2] = 8'($urandom);
    for (i = 0; i < 3; i++)
      apb(1'b1, 10'(`FPRMD_OFF_TARGET1 + 16 * i), tg[i]);
    measure;
    for (i = 0; i < 3; i++)
      rdchk(10'(`FPRMD_OFF_DUTY1 + 16 * i), tg[i]);
    measure;
    `CHK(hi1, hi_exp(tg[0]))
    `CHK(hi2, hi_exp(tg[1]))
    `CHK(hi3, hi_exp(tg[2]))
    // auto mode below threshold: floors frozen, select picks floor or off
    apb(1'b1, `FPRMD_OFF_MODE, 32'h13);
    apb(1'b1, `FPRMD_OFF_FLOOR1, 32'h5A);
    rdchk(`FPRMD_OFF_FLOOR1, fl[0]);
    measure;
    measure;
    `CHK(hi1, 9'h100)
    `CHK(hi2, 9'h000)
    `CHK(hi3, 9'h000)
    apb(1'b1, `FPRMD_OFF_MODE, 32'h0);
    measure;
    // slew on for outputs two and three: their duties must not jump
    r2 = 3'($urandom); r3 = 3'($urandom);
    apb(1'b1, `FPRMD_OFF_SLEW, {24'h0, 1'b1, r2, 1'b1, r3});
    rdchk(`FPRMD_OFF_SLEW, {1'b1, r2, 1'b1, r3});
    for (i = 0; i < 3; i++)
      apb(1'b1, 10'(`FPRMD_OFF_TARGET1 + 16 * i), ~tg[i]);
    measure;
    rdchk(`FPRMD_OFF_DUTY1, ~tg[0]);
    rdchk(`FPRMD_OFF_DUTY2, tg[1]);
    rdchk(`FPRMD_OFF_DUTY3, tg[2]);
    apb(1'b1, `FPRMD_OFF_SLEW, {24'h0, 1'b0, r2, 1'b1, r3});
    measure;
    rdchk(`FPRMD_OFF_DUTY2, ~tg[1]);
    rdchk(`FPRMD_OFF_DUTY3, tg[2]);
    // every rate code in both fields
    for (i = 0; i < 8; i++) begin
      apb(1'b1, `FPRMD_OFF_SLEW, {24'h0, 1'b0, 3'(i), 1'b0, 3'(7 - i)});
      rdchk(`FPRMD_OFF_SLEW, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
    end
    end_sim;
  end
endmodule // testbench
